// ### logic/pscf_defs.svh
// Offsets, field positions, reset values and timing counts of the supply configuration block
`ifndef PSCF_DEFS_SVH
`define PSCF_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PSCF_AWAKE_OFS        8'h18
`define PSCF_SLEEP1_OFS       8'h1C
`define PSCF_SLEEP2_OFS       8'h20
`define PSCF_STATUS_OFS       8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define PSCF_CORE_EN_BIT      0
`define PSCF_ANL_EN_BIT       1
`define PSCF_PLL_EN_BIT       4
`define PSCF_IO_EN_BIT        5
`define PSCF_CORE_PFM_BIT     8
`define PSCF_ANL_PFM_BIT      9
`define PSCF_TILE_OFF_BIT     14
`define PSCF_DWELL_LSB        16
`define PSCF_DWELL_MSB        20
`define PSCF_STATE_LSB        16
`define PSCF_STATE_MSB        18

// ****************************************************************
// Reset values
// ****************************************************************
`define PSCF_DWELL_RST        5'h10
`define PSCF_AWAKE_CORE_RST   1'b1
`define PSCF_AWAKE_PLL_RST    1'b1
`define PSCF_AWAKE_IO_RST     1'b1
`define PSCF_SLEEP1_CORE_RST  1'b0
`define PSCF_SLEEP1_PLL_RST   1'b0
`define PSCF_SLEEP1_IO_RST    1'b1
`define PSCF_SLEEP2_CORE_RST  1'b0
`define PSCF_SLEEP2_PLL_RST   1'b0
`define PSCF_SLEEP2_IO_RST    1'b0
`define PSCF_ANL_EN_FIXED     1'b1

// ****************************************************************
// Timing
// ****************************************************************
`define PSCF_DWELL_CNT_W      32

`endif

// ### logic/pscf_pkg.sv
// Types shared by the supply configuration sequencer, its checker and the bench models
package pscf_pkg;

   // Sequencer states, declared in their encoded order 0 to 7
   typedef enum logic [2:0] {
      ST_RESET,
      ST_ASLEEP,
      ST_WAKE1,
      ST_WAKE2,
      ST_AWAKE_WAIT,
      ST_AWAKE,
      ST_SLEEP1,
      ST_SLEEP2
   } pscf_state_t;

   // One state's programmable configuration
   typedef struct packed {
      logic [4:0] dwell;
      logic       tile_clk_off;
      logic       anl_pfm;
      logic       core_pfm;
      logic       io_en;
      logic       pll_en;
      logic       core_en;
   } pscf_cfg_t;

   // Controls driven to the analogue regulators and tile clock
   typedef struct packed {
      logic tile_clk_off;
      logic anl_pfm;
      logic core_pfm;
      logic io_en;
      logic pll_en;
      logic anl_en;
      logic core_en;
   } pscf_drive_t;

   // Supply good reports, one per supply
   typedef struct packed {
      logic io_good;
      logic pll_good;
      logic anl_good;
      logic core_good;
   } pscf_good_t;

endpackage

// ### logic/pscf_dwell_timer.sv
// Dwell timer: counts 2**n clock cycles after a load pulse
`timescale 1ns/1ns
`include "pscf_defs.svh"

module pscf_dwell_timer #(
   parameter int CNT_W = `PSCF_DWELL_CNT_W
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       load_i,
   input  wire logic [4:0] log2_i,
   // Status
   output logic            expired_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } pscf_tmr_t;

   pscf_tmr_t tmr_reg;
   pscf_tmr_t tmr_next;

   // Loaded with 2**n - 1 so the owning state lasts at least 2**n cycles, longer while its supplies are not good
   always_comb begin
      tmr_next = tmr_reg;
      if (load_i) begin
         tmr_next.cnt = CNT_W'((33'h1 << log2_i) - 33'h1);
      end else if (tmr_reg.cnt != '0) begin
         tmr_next.cnt = tmr_reg.cnt - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign expired_o = (tmr_reg.cnt == '0);

endmodule // pscf_dwell_timer

// ### logic/pscf_sequencer.sv
// Power state supply configuration registers with Wishbone slave and state sequencer
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "pscf_defs.svh"

// Contract
// - In awake state, drive supplies, modulation and tile clock from awake register.
// - In first sleeping state apply its register and stay its programmed dwell.
// - In second sleeping state apply its register and stay its programmed dwell.
// - Dwell field n holds the state 2**n cycles; field resets to 16.
// - Bit 14 set stops the tile clock in the active state; resets zero.
// - Bit 9 picks analogue converter modulation: 0 PWM, 1 PFM.
// - Bit 8 picks core converter modulation: 0 PWM, 1 PFM.
// - Bit 5 enables IO supply; resets 1 awake and first sleep, 0 second.
// - Bit 4 enables PLL regulator; resets 1 only in awake register.
// - Bit 1 analogue converter enable is read-only, fixed at one.
// - Bit 0 enables core converter; resets 1 awake, 0 both sleeping.
// - After dwell expires, advance only when every enabled supply reports good.
// - State encoded in three bits, 0 reset through 7 second sleeping.
module pscf_sequencer #(
   parameter int ADR_W = 8
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [ADR_W-1:0]    adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // Sequencing requests
   input  wire logic                sleep_req_i,
   input  wire logic                wake_req_i,
   // Supply good reports from the analogue side
   input  wire pscf_pkg::pscf_good_t good_i,
   // Supply and clock controls
   output pscf_pkg::pscf_drive_t    drive_o,
   output logic      [2:0]          state_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      pscf_pkg::pscf_cfg_t   awake;
      pscf_pkg::pscf_cfg_t   sleep1;
      pscf_pkg::pscf_cfg_t   sleep2;
      pscf_pkg::pscf_state_t st;
      pscf_pkg::pscf_drive_t drv;
      logic [3:0]            good_s1;
      logic [3:0]            good_s2;
      logic [3:0]            good_s3;
      logic [3:0]            good_q;
      logic [31:0]           rdata;
      logic                  ack;
   } pscf_main_t;

   pscf_main_t r_reg;
   pscf_main_t r_next;

   logic       tmr_load;
   logic [4:0] tmr_log2;
   logic       tmr_expired;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic pscf_pkg::pscf_cfg_t cfg_rst(input logic core, input logic pll,
                                                   input logic io);
      pscf_pkg::pscf_cfg_t c;
      c              = '0;
      c.dwell        = `PSCF_DWELL_RST;
      c.tile_clk_off = 1'b0;
      c.core_en      = core;
      c.pll_en       = pll;
      c.io_en        = io;
      return c;
   endfunction

   // Register image; reserved bits read zero
   function automatic logic [31:0] cfg_word(input pscf_pkg::pscf_cfg_t c, input logic dw);
      logic [31:0] w;
      w                       = 32'h0000_0000;
      w[`PSCF_CORE_EN_BIT]    = c.core_en;
      w[`PSCF_ANL_EN_BIT]     = `PSCF_ANL_EN_FIXED;
      w[`PSCF_PLL_EN_BIT]     = c.pll_en;
      w[`PSCF_IO_EN_BIT]      = c.io_en;
      w[`PSCF_CORE_PFM_BIT]   = c.core_pfm;
      w[`PSCF_ANL_PFM_BIT]    = c.anl_pfm;
      w[`PSCF_TILE_OFF_BIT]   = c.tile_clk_off;
      if (dw) begin
         w[`PSCF_DWELL_MSB:`PSCF_DWELL_LSB] = c.dwell;
      end
      return w;
   endfunction

   // Byte-lane write; bit 1 has no storage so writes to it are dropped
   function automatic pscf_pkg::pscf_cfg_t cfg_write(input pscf_pkg::pscf_cfg_t c,
                                                     input logic [31:0] d,
                                                     input logic [3:0] s,
                                                     input logic dw);
      pscf_pkg::pscf_cfg_t n;
      n = c;
      if (s[0]) begin
         n.core_en = d[`PSCF_CORE_EN_BIT];
         n.pll_en  = d[`PSCF_PLL_EN_BIT];
         n.io_en   = d[`PSCF_IO_EN_BIT];
      end
      if (s[1]) begin
         n.core_pfm     = d[`PSCF_CORE_PFM_BIT];
         n.anl_pfm      = d[`PSCF_ANL_PFM_BIT];
         n.tile_clk_off = d[`PSCF_TILE_OFF_BIT];
      end
      if (s[2] && dw) begin
         n.dwell = d[`PSCF_DWELL_MSB:`PSCF_DWELL_LSB];
      end
      return n;
   endfunction

   // Controls that a configuration produces
   function automatic pscf_pkg::pscf_drive_t cfg_drive(input pscf_pkg::pscf_cfg_t c);
      pscf_pkg::pscf_drive_t v;
      v.core_en      = c.core_en;
      v.anl_en       = `PSCF_ANL_EN_FIXED;
      v.pll_en       = c.pll_en;
      v.io_en        = c.io_en;
      v.core_pfm     = c.core_pfm;
      v.anl_pfm      = c.anl_pfm;
      v.tile_clk_off = c.tile_clk_off;
      return v;
   endfunction

   // Status image: state in bits 18:16, live controls at their config positions
   function automatic logic [31:0] status_word(input pscf_pkg::pscf_state_t s,
                                               input pscf_pkg::pscf_drive_t d);
      logic [31:0] w;
      w                                  = 32'h0000_0000;
      w[`PSCF_STATE_MSB:`PSCF_STATE_LSB] = s;
      w[`PSCF_CORE_EN_BIT]               = d.core_en;
      w[`PSCF_ANL_EN_BIT]                = d.anl_en;
      w[`PSCF_PLL_EN_BIT]                = d.pll_en;
      w[`PSCF_IO_EN_BIT]                 = d.io_en;
      w[`PSCF_CORE_PFM_BIT]              = d.core_pfm;
      w[`PSCF_ANL_PFM_BIT]               = d.anl_pfm;
      w[`PSCF_TILE_OFF_BIT]              = d.tile_clk_off;
      return w;
   endfunction

   // ****************************************************************
   // Supply good qualification
   // ****************************************************************
   logic [3:0] sup_en;
   logic [3:0] sup_met;

   // Same bit order as the good reports: core, analogue, PLL, IO
   assign sup_en = {r_reg.drv.io_en, r_reg.drv.pll_en, r_reg.drv.anl_en, r_reg.drv.core_en};

   // A supply switched off in this state never holds the sequencer back
   for (genvar g = 0; g < 4; g++) begin : g_sup_met
      assign sup_met[g] = !sup_en[g] || r_reg.good_q[g];
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   logic                  bus_req;
   logic                  sup_ok;
   logic [3:0]            agree;
   pscf_pkg::pscf_cfg_t   st_cfg;

   always_comb begin
      r_next   = r_reg;
      bus_req  = cyc_i && stb_i && !r_reg.ack;
      tmr_load = 1'b0;
      tmr_log2 = r_reg.sleep1.dwell;
      st_cfg   = r_reg.awake;

      // Supply good filter: a change counts once stages two and three agree
      // Only stage two reads stage one, which may still be settling
      r_next.good_s1 = good_i;
      r_next.good_s2 = r_reg.good_s1;
      r_next.good_s3 = r_reg.good_s2;
      agree          = ~(r_reg.good_s2 ^ r_reg.good_s3);
      r_next.good_q  = (agree & r_reg.good_s3) | (~agree & r_reg.good_q);

      // Every supply enabled in the current state must report good
      sup_ok = &sup_met;

      // Wishbone: one wait state, ack drops the cycle after it is given
      r_next.ack = bus_req;
      if (bus_req) begin
         r_next.rdata = 32'h0000_0000;
         case (adr_i)
            `PSCF_AWAKE_OFS: begin
               r_next.rdata = cfg_word(r_reg.awake, 1'b0);
               if (we_i) begin
                  r_next.awake = cfg_write(r_reg.awake, dat_i, sel_i, 1'b0);
               end
            end
            `PSCF_SLEEP1_OFS: begin
               r_next.rdata = cfg_word(r_reg.sleep1, 1'b1);
               if (we_i) begin
                  r_next.sleep1 = cfg_write(r_reg.sleep1, dat_i, sel_i, 1'b1);
               end
            end
            `PSCF_SLEEP2_OFS: begin
               r_next.rdata = cfg_word(r_reg.sleep2, 1'b1);
               if (we_i) begin
                  r_next.sleep2 = cfg_write(r_reg.sleep2, dat_i, sel_i, 1'b1);
               end
            end
            `PSCF_STATUS_OFS: begin
               r_next.rdata = status_word(r_reg.st, r_reg.drv);
            end
            default: begin
               // Unmapped addresses answer zero and drop writes
               r_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // ****************************************************************
      // Sequencer
      // ****************************************************************
      case (r_reg.st)
         pscf_pkg::ST_RESET: begin
            r_next.st = pscf_pkg::ST_AWAKE_WAIT;
         end
         pscf_pkg::ST_AWAKE_WAIT: begin
            if (sup_ok) begin
               r_next.st = pscf_pkg::ST_AWAKE;
            end
         end
         pscf_pkg::ST_AWAKE: begin
            // Sleep requests are ignored in every other state
            if (sleep_req_i) begin
               r_next.st = pscf_pkg::ST_SLEEP1;
               tmr_load  = 1'b1;
               tmr_log2  = r_reg.sleep1.dwell;
            end
         end
         pscf_pkg::ST_SLEEP1: begin
            if (tmr_expired && sup_ok) begin
               r_next.st = pscf_pkg::ST_SLEEP2;
               tmr_load  = 1'b1;
               tmr_log2  = r_reg.sleep2.dwell;
            end
         end
         pscf_pkg::ST_SLEEP2: begin
            // Asleep keeps the second sleeping controls
            if (tmr_expired && sup_ok) begin
               r_next.st = pscf_pkg::ST_ASLEEP;
            end
         end
         pscf_pkg::ST_ASLEEP: begin
            if (wake_req_i) begin
               r_next.st = pscf_pkg::ST_WAKE1;
            end
         end
         pscf_pkg::ST_WAKE1: begin
            // Waking phases have no dwell; they wait only for supplies
            if (sup_ok) begin
               r_next.st = pscf_pkg::ST_WAKE2;
            end
         end
         pscf_pkg::ST_WAKE2: begin
            if (sup_ok) begin
               r_next.st = pscf_pkg::ST_AWAKE_WAIT;
            end
         end
         default: begin
            r_next.st = pscf_pkg::ST_RESET;
         end
      endcase

      // Controls follow the state being entered, so they change with it.
      // Asleep borrows the second sleeping set; the other states without one take the awake set.
      case (r_next.st)
         pscf_pkg::ST_SLEEP1: begin
            st_cfg = r_reg.sleep1;
         end
         pscf_pkg::ST_SLEEP2,
         pscf_pkg::ST_ASLEEP: begin
            st_cfg = r_reg.sleep2;
         end
         default: begin
            st_cfg = r_reg.awake;
         end
      endcase
      r_next.drv = cfg_drive(st_cfg);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // One reset edge restores every image, the state and the controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg        <= '0;
         r_reg.awake  <= cfg_rst(`PSCF_AWAKE_CORE_RST, `PSCF_AWAKE_PLL_RST,
                                 `PSCF_AWAKE_IO_RST);
         r_reg.sleep1 <= cfg_rst(`PSCF_SLEEP1_CORE_RST, `PSCF_SLEEP1_PLL_RST,
                                 `PSCF_SLEEP1_IO_RST);
         r_reg.sleep2 <= cfg_rst(`PSCF_SLEEP2_CORE_RST, `PSCF_SLEEP2_PLL_RST,
                                 `PSCF_SLEEP2_IO_RST);
         r_reg.st     <= pscf_pkg::ST_RESET;
         r_reg.drv    <= cfg_drive(cfg_rst(`PSCF_AWAKE_CORE_RST, `PSCF_AWAKE_PLL_RST,
                                           `PSCF_AWAKE_IO_RST));
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************************************
   // Dwell timer
   // ****************************************************************
   // Count width covers the longest dwell of 2**31 cycles
   pscf_dwell_timer #(
      .CNT_W (`PSCF_DWELL_CNT_W)
   ) u_dwell (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (tmr_load),
      .log2_i    (tmr_log2),
      .expired_o (tmr_expired)
   );

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign dat_o   = r_reg.rdata;
   assign ack_o   = r_reg.ack;
   assign drive_o = r_reg.drv;
   assign state_o = r_reg.st;

endmodule // pscf_sequencer

// ### tb/pscf_sequencer_checker.sv
// Concurrent checks on the supply configuration sequencer ports
`timescale 1ns/1ns
`include "pscf_defs.svh"

module pscf_sequencer_checker #(
   parameter int ADR_W = 8
) (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Wishbone slave
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [ADR_W-1:0]      adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   input  wire logic [31:0]           dat_o,
   input  wire logic                  ack_o,
   // Sequencing
   input  wire logic                  sleep_req_i,
   input  wire logic                  wake_req_i,
   input  wire pscf_pkg::pscf_good_t  good_i,
   input  wire pscf_pkg::pscf_drive_t drive_o,
   input  wire logic [2:0]            state_o
);
   // ************************************************
   // Shadow registers and dwell counter
   // ************************************************
   logic [31:0] sh0, sh1, sh2, lane, cnt, cnt_q;
   logic [6:0]  d0, d1, d2;
   logic [2:0]  st_q;
   logic        wr;

   function automatic logic [31:0] upd(input logic [31:0] r, input logic [31:0] m);
      return (r & ~(m & lane)) | (dat_i & m & lane);
   endfunction

   function automatic logic [6:0] drv(input logic [31:0] r);
      return {r[14], r[9], r[8], r[5], r[4], r[1], r[0]};
   endfunction

   assign lane = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign wr   = cyc_i & stb_i & we_i & ~ack_o;
   assign d0   = drv(sh0);
   assign d1   = drv(sh1);
   assign d2   = drv(sh2);
   // Counts cycles already spent in the present state
   assign cnt  = (state_o == st_q) ? cnt_q + 32'h1 : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh0   <= 32'h0000_0033;
         sh1   <= 32'h0010_0022;
         sh2   <= 32'h0010_0002;
         st_q  <= 3'h0;
         cnt_q <= 32'h0;
      end else begin
         if (wr && adr_i == ADR_W'(`PSCF_AWAKE_OFS)) sh0 <= upd(sh0, 32'h0000_4331);
         if (wr && adr_i == ADR_W'(`PSCF_SLEEP1_OFS)) sh1 <= upd(sh1, 32'h001F_4331);
         if (wr && adr_i == ADR_W'(`PSCF_SLEEP2_OFS)) sh2 <= upd(sh2, 32'h001F_4331);
         st_q  <= state_o;
         cnt_q <= cnt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_anl_fixed: assert property (drive_o.anl_en)
      else $error("analogue converter enable low");
   a_awake_cfg: assert property ((state_o == 3'h5 && $past(state_o) == 3'h4) |-> drive_o == $past(d0))
      else $error("awake controls differ from awake register");
   a_sleep1_cfg: assert property ((state_o == 3'h6 && $past(state_o) == 3'h5) |-> drive_o == $past(d1))
      else $error("first sleep controls differ from its register");
   a_sleep2_cfg: assert property ((state_o == 3'h7 && $past(state_o) == 3'h6) |-> drive_o == $past(d2))
      else $error("second sleep controls differ from its register");
   a_dwell_one: assert property ((state_o == 3'h6 && cnt < ((32'h1 << sh1[20:16]) - 32'h1)) |=> state_o == 3'h6)
      else $error("first sleep left before its dwell");
   a_dwell_two: assert property ((state_o == 3'h7 && cnt < ((32'h1 << sh2[20:16]) - 32'h1)) |=> state_o == 3'h7)
      else $error("second sleep left before its dwell");
   a_sleep_go: assert property ((state_o == 3'h5 && sleep_req_i) |=> state_o == 3'h6)
      else $error("sleep request not followed by first sleep");
   a_awake_hold: assert property ((state_o == 3'h5 && !sleep_req_i) |=> state_o == 3'h5)
      else $error("awake left without sleep request");
   a_late_order: assert property (state_o == 3'h7 |=> state_o == 3'h7 || state_o == 3'h1)
      else $error("second sleep followed by wrong state");
   a_reset_state: assert property (disable iff (1'b0) rst_i |=> state_o == 3'h0 && !ack_o)
      else $error("reset did not clear state");
endmodule // pscf_sequencer_checker

// ### tb/pscf_supply_model.sv
// Behavioural regulators: good reports follow enables after a lag
`timescale 1ns/1ns

module pscf_supply_model #(
   parameter int LAG = 2
) (
   // Clock
   input  wire logic                  clk_i,
   // Controls and injected faults
   input  wire pscf_pkg::pscf_drive_t drive_i,
   input  wire logic [3:0]            bad_i,
   // Good reports
   output pscf_pkg::pscf_good_t       good_o
);
   logic [3:0] en;
   logic [3:0] pipe [LAG];

   assign en = {drive_i.io_en, drive_i.pll_en, drive_i.anl_en, drive_i.core_en};

   // Good only after LAG cycles on, never while off
   always_ff @(posedge clk_i) begin
      pipe[0] <= en;
      for (int i = 1; i < LAG; i++) begin
         pipe[i] <= pipe[i-1] & en;
      end
   end

   assign good_o = pipe[LAG-1] & en & ~bad_i;
endmodule // pscf_supply_model

// ### tb/testbench.sv
// Self-checking bench for the supply configuration sequencer
`timescale 1ns/1ns
`include "pscf_defs.svh"

module testbench;
   typedef struct packed {
      logic [7:0]  adr;
      logic        we;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic [31:0] exp;
   } pscf_row_t;

   logic                  clk_i = 1'b0;
   logic                  rst_i = 1'b1;
   logic                  cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_req_i = 1'b0, wake_req_i = 1'b0, ack_o;
   logic [7:0]            adr_i = 8'h00;
   logic [3:0]            sel_i = 4'h0, bad = 4'h0;
   logic [31:0]           dat_i = 32'h0, dat_o, rd;
   logic [2:0]            state_o;
   pscf_pkg::pscf_good_t  good;
   pscf_pkg::pscf_drive_t drive_o;
   int                    fail_count = 0, comparisons = 0, cycles = 0, n;
   pscf_row_t             rows [10] = '{
      '{`PSCF_STATUS_OFS, 1'b0, 32'h0, 4'h0, 32'h0005_0033},
      '{`PSCF_AWAKE_OFS, 1'b0, 32'h0, 4'h0, 32'h0000_0033},
      '{`PSCF_SLEEP1_OFS, 1'b0, 32'h0, 4'h0, 32'h0010_0022},
      '{`PSCF_SLEEP2_OFS, 1'b0, 32'h0, 4'h0, 32'h0010_0002},
      '{`PSCF_AWAKE_OFS, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0000_4333},
      '{`PSCF_SLEEP1_OFS, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h001F_4333},
      '{`PSCF_SLEEP2_OFS, 1'b1, 32'hFFFF_FFFF, 4'h2, 32'h0010_4302},
      '{`PSCF_SLEEP2_OFS, 1'b1, 32'h0, 4'h4, 32'h0000_4302},
      '{`PSCF_AWAKE_OFS, 1'b1, 32'h0, 4'h1, 32'h0000_4302},
      '{8'h28, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0}};

   always #25 clk_i = ~clk_i;

   pscf_sequencer #(.ADR_W(8)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_req_i(sleep_req_i),
      .wake_req_i(wake_req_i), .good_i(good), .drive_o(drive_o), .state_o(state_o));

   pscf_supply_model #(.LAG(2)) sup_u (.clk_i(clk_i), .drive_i(drive_o), .bad_i(bad), .good_o(good));

   // ************************************************
   // Tasks
   // ************************************************
   task finish_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic cycle, held until ack is sampled
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      q = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      if (k >= 50) chk(32'h0, 32'h1);
   endtask

   task tick;
      @(posedge clk_i);
      #1;
   endtask

   task wait_st(input logic [2:0] s);
      for (int k = 0; k < 300 && state_o !== s; k++) tick;
   endtask

   task dur(input logic [2:0] s);
      for (n = 0; n < 1000 && state_o === s; n++) tick;
   endtask

   task nap(input int d6);
      @(posedge clk_i);
      sleep_req_i <= 1'b1;
      @(posedge clk_i);
      sleep_req_i <= 1'b0;
      #1;
      chk(state_o, 3'h6);
      chk(drive_o, 7'h56);
      dur(3'h6);
      chk(n, d6);
      chk(state_o, 3'h7);
      chk(drive_o, 7'h2A);
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         finish_test();
      end
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk(state_o, 3'h0);
      chk(drive_o, 7'h0F);
      tick;
      chk(state_o, 3'h4);
      wait_st(3'h5);
      chk(state_o, 3'h5);
      foreach (rows[i]) begin
         if (rows[i].we) wb(rows[i].adr, 1'b1, rows[i].dat, rows[i].sel, rd);
         wb(rows[i].adr, 1'b0, 32'h0, 4'hF, rd);
         chk(rd, rows[i].exp);
      end
      wb(`PSCF_AWAKE_OFS, 1'b1, 32'h0000_4333, 4'hF, rd);
      repeat (3) tick;
      chk(drive_o, 7'h7F);
      // Wake request outside asleep must be ignored
      @(posedge clk_i);
      wake_req_i <= 1'b1;
      wb(`PSCF_AWAKE_OFS, 1'b1, 32'h0000_0033, 4'hF, rd);
      wake_req_i <= 1'b0;
      repeat (3) tick;
      chk(drive_o, 7'h0F);
      chk(state_o, 3'h5);
      wb(`PSCF_SLEEP1_OFS, 1'b1, 32'h0002_4110, 4'hF, rd);
      wb(`PSCF_SLEEP2_OFS, 1'b1, 32'h0004_0220, 4'hF, rd);
      nap(4);
      dur(3'h7);
      chk(n, 16);
      chk(state_o, 3'h1);
      @(posedge clk_i);
      wake_req_i <= 1'b1;
      @(posedge clk_i);
      wake_req_i <= 1'b0;
      wait_st(3'h5);
      chk(drive_o, 7'h0F);
      // Shortest dwell, then a supply held bad past expiry
      wb(`PSCF_SLEEP1_OFS, 1'b1, 32'h0000_4110, 4'hF, rd);
      bad <= 4'h8;
      nap(1);
      repeat (40) tick;
      chk(state_o, 3'h7);
      @(posedge clk_i);
      bad <= 4'h0;
      wait_st(3'h1);
      chk(state_o, 3'h1);
      // Mid-run reset restores images written earlier
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk(state_o, 3'h0);
      chk(drive_o, 7'h0F);
      tick;
      chk(state_o, 3'h4);
      wb(`PSCF_SLEEP1_OFS, 1'b0, 32'h0, 4'hF, rd);
      chk(rd, 32'h0010_0022);
      finish_test();
   end
endmodule // testbench

bind pscf_sequencer pscf_sequencer_checker #(.ADR_W(ADR_W)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_req_i(sleep_req_i),
   .wake_req_i(wake_req_i), .good_i(good_i), .drive_o(drive_o), .state_o(state_o));
